//--- csp_defines.svh
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// ==========================================================
// bus addressing
`define CSP_SLAVE_ADDR 7'h09
`define CSP_DIR_WRITE 1'b0
`define CSP_DIR_READ 1'b1
`define CSP_MAKER_IDENTITY_REGISTER 8'h2E
`define CSP_PART_IDENTITY_REGISTER 8'h2F

// ==========================================================
// pin levels and enables
`define CSP_RELEASED 1'b1
`define CSP_DRIVEN 1'b0
`define CSP_PIN_LOW 1'b0
`define CSP_SYNC_IDLE 3'h7
`define CSP_LEVEL_HIGH 1'b1
`define CSP_RX_FILL 8'hFF

// ==========================================================
// byte layout
`define CSP_MSB 7
`define CSP_FIRST_BIT 4'h0
`define CSP_ACK_BIT 4'h8
`define CSP_BIT_STEP 4'h1

// ==========================================================
// timing
`define CSP_CNT_W 11
`define CSP_CNT_STEP 11'h001
`define CSP_CNT_ZERO 11'h000
`define CSP_CLK_PERIOD_NS 4
`define CSP_STD_RATE_KBPS 100
`define CSP_FAST_RATE_KBPS 400
`define CSP_STD_QTR_NS (1000000 / (4 * `CSP_STD_RATE_KBPS))
`define CSP_FAST_QTR_NS (1000000 / (4 * `CSP_FAST_RATE_KBPS))
`define CSP_STD_QTR_CYC ((`CSP_STD_QTR_NS + `CSP_CLK_PERIOD_NS - 1) / `CSP_CLK_PERIOD_NS)
`define CSP_FAST_QTR_CYC ((`CSP_FAST_QTR_NS + `CSP_CLK_PERIOD_NS - 1) / `CSP_CLK_PERIOD_NS)

`endif

//--- csp_master.sv
`timescale 1ns/100ps
`include "csp_defines.svh"

module csp_master
   import csp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic fast_mode,
   input wire logic cmd_valid,
   input wire csp_cmd_t cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output csp_rsp_t rsp,
   output logic bus_busy,
   input wire logic scl_sense,
   output logic scl_drive,
   output logic scl_oe_n,
   input wire logic sda_sense,
   output logic sda_drive,
   output logic sda_oe_n
);

   // ==========================================================
   // pin synchronisers
   logic scl_lvl;
   logic sda_lvl;

   csp_pin_sync u_scl_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin(scl_sense),
      .level(scl_lvl)
   );

   csp_pin_sync u_sda_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin(sda_sense),
      .level(sda_lvl)
   );

   // ==========================================================
   // phase timing
   csp_st_t st;
   csp_st_t next_st;
   logic [`CSP_CNT_W-1:0] qtr;
   logic [`CSP_CNT_W-1:0] half;
   logic tx;
   logic ack_ours;

   // quarter and half bit marks for the chosen rate
   assign qtr = st.fast ? `CSP_CNT_W'(`CSP_FAST_QTR_CYC - 1)
                        : `CSP_CNT_W'(`CSP_STD_QTR_CYC - 1);
   assign half = st.fast ? `CSP_CNT_W'(2 * `CSP_FAST_QTR_CYC - 1)
                         : `CSP_CNT_W'(2 * `CSP_STD_QTR_CYC - 1);

   // direction of the current byte and our answer on received bytes
   assign tx = (st.seg != csp_seg_rlo) && (st.seg != csp_seg_rhi);
   assign ack_ours = (st.seg == csp_seg_rlo) && !st.cmd.one_byte;

   // byte that goes out for a given segment
   function automatic logic [`CSP_MSB:0] byte_for(input csp_seg_t seg,
                                                 input csp_cmd_t c);
      logic [`CSP_MSB:0] b;
      b = `CSP_RX_FILL;
      unique case (seg)
         csp_seg_addr_w: b = {`CSP_SLAVE_ADDR, `CSP_DIR_WRITE};
         csp_seg_reg: b = c.reg_addr;
         csp_seg_wlo: b = c.wdata.lo;
         csp_seg_whi: b = c.wdata.hi;
         csp_seg_addr_r: b = {`CSP_SLAVE_ADDR, `CSP_DIR_READ};
         csp_seg_rlo: b = `CSP_RX_FILL;
         csp_seg_rhi: b = `CSP_RX_FILL;
      endcase
      return b;
   endfunction : byte_for

   // ==========================================================
   // bus sequencer
   always_comb begin
      next_st = st;
      next_st.rsp_valid = 1'b0;
      unique case (st.fsm)
         // wait for a request on a free bus
         csp_idle: begin
            if (cmd_valid && st.cmd_ready && scl_lvl && sda_lvl) begin
               next_st.cmd = cmd;
               next_st.fast = fast_mode;
               next_st.rsp = '0;
               next_st.cmd_ready = 1'b0;
               next_st.bus_busy = 1'b1;
               next_st.seg = csp_seg_addr_w;
               next_st.sda_oe_n = `CSP_DRIVEN;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_start;
            end
         end
         // data low with clock high, then clock low and load a byte
         csp_start: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == half) begin
               next_st.scl_oe_n = `CSP_DRIVEN;
               next_st.shreg = byte_for(st.seg, st.cmd);
               next_st.bitn = `CSP_FIRST_BIT;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_low;
            end
         end
         // clock low: set data at the quarter mark
         csp_low: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == qtr) begin
               if (st.bitn == `CSP_ACK_BIT) begin
                  next_st.sda_oe_n = (!tx && ack_ours) ? `CSP_DRIVEN
                                                       : `CSP_RELEASED;
               end else begin
                  next_st.sda_oe_n = (tx && !st.shreg[`CSP_MSB]) ? `CSP_DRIVEN
                                                                : `CSP_RELEASED;
               end
            end
            if (st.cnt == half) begin
               next_st.scl_oe_n = `CSP_RELEASED;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_rise;
            end
         end
         // released clock, wait while a slave holds it low
         csp_rise: begin
            if (scl_lvl) begin
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_high;
            end
         end
         // clock high: sample at the end, then choose what follows
         csp_high: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == half) begin
               next_st.scl_oe_n = `CSP_DRIVEN;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_low;
               if (st.bitn != `CSP_ACK_BIT) begin
                  next_st.shreg = {st.shreg[`CSP_MSB-1:0], sda_lvl};
                  next_st.bitn = st.bitn + `CSP_BIT_STEP;
               end else if (tx && sda_lvl) begin
                  next_st.rsp.nack = 1'b1;
                  next_st.fsm = csp_p_low;
               end else begin
                  next_st.bitn = `CSP_FIRST_BIT;
                  unique case (st.seg)
                     csp_seg_addr_w: begin
                        next_st.seg = csp_seg_reg;
                        next_st.shreg = byte_for(csp_seg_reg, st.cmd);
                     end
                     csp_seg_reg: begin
                        if (st.cmd.rd) begin
                           next_st.seg = csp_seg_addr_r;
                           next_st.fsm = csp_rs_low;
                        end else begin
                           next_st.seg = csp_seg_wlo;
                           next_st.shreg = byte_for(csp_seg_wlo, st.cmd);
                        end
                     end
                     csp_seg_wlo: begin
                        if (st.cmd.one_byte) begin
                           next_st.fsm = csp_p_low;
                        end else begin
                           next_st.seg = csp_seg_whi;
                           next_st.shreg = byte_for(csp_seg_whi, st.cmd);
                        end
                     end
                     csp_seg_whi: begin
                        next_st.fsm = csp_p_low;
                     end
                     csp_seg_addr_r: begin
                        next_st.seg = csp_seg_rlo;
                        next_st.shreg = byte_for(csp_seg_rlo, st.cmd);
                     end
                     csp_seg_rlo: begin
                        next_st.rsp.rdata.lo = st.shreg;
                        if (st.cmd.one_byte) begin
                           next_st.fsm = csp_p_low;
                        end else begin
                           next_st.seg = csp_seg_rhi;
                        end
                     end
                     csp_seg_rhi: begin
                        next_st.rsp.rdata.hi = st.shreg;
                        next_st.fsm = csp_p_low;
                     end
                  endcase
               end
            end
         end
         // repeated start: release data while clock low
         csp_rs_low: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == qtr) begin
               next_st.sda_oe_n = `CSP_RELEASED;
            end
            if (st.cnt == half) begin
               next_st.scl_oe_n = `CSP_RELEASED;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_rs_rise;
            end
         end
         csp_rs_rise: begin
            if (scl_lvl) begin
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_rs_high;
            end
         end
         // clock high, pull data low for the repeated start
         csp_rs_high: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == half) begin
               next_st.sda_oe_n = `CSP_DRIVEN;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_start;
            end
         end
         // stop: data low while clock low
         csp_p_low: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == qtr) begin
               next_st.sda_oe_n = `CSP_DRIVEN;
            end
            if (st.cnt == half) begin
               next_st.scl_oe_n = `CSP_RELEASED;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_p_rise;
            end
         end
         csp_p_rise: begin
            if (scl_lvl) begin
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_p_high;
            end
         end
         // clock high, data rises to make the stop
         csp_p_high: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == half) begin
               next_st.sda_oe_n = `CSP_RELEASED;
               next_st.cnt = `CSP_CNT_ZERO;
               next_st.fsm = csp_p_done;
            end
         end
         // bus free time, then answer
         csp_p_done: begin
            next_st.cnt = st.cnt + `CSP_CNT_STEP;
            if (st.cnt == half) begin
               next_st.bus_busy = 1'b0;
               next_st.rsp_valid = 1'b1;
               next_st.cmd_ready = 1'b1;
               next_st.fsm = csp_idle;
            end
         end
         default: begin
            next_st.scl_oe_n = `CSP_RELEASED;
            next_st.sda_oe_n = `CSP_RELEASED;
            next_st.fsm = csp_idle;
         end
      endcase
   end

   // state register, both lines released after reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st <= '0;
         st.fsm <= csp_idle;
         st.scl_oe_n <= `CSP_RELEASED;
         st.sda_oe_n <= `CSP_RELEASED;
         st.pin_low <= `CSP_PIN_LOW;
         st.cmd_ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign cmd_ready = st.cmd_ready;
   assign rsp_valid = st.rsp_valid;
   assign rsp = st.rsp;
   assign bus_busy = st.bus_busy;
   assign scl_drive = st.pin_low;
   assign scl_oe_n = st.scl_oe_n;
   assign sda_drive = st.pin_low;
   assign sda_oe_n = st.sda_oe_n;

   // ==========================================================
   // checks
   idle_release_a: assert property (@(posedge clk_sys) disable iff (reset)
      st.fsm == csp_idle |-> st.scl_oe_n && st.sda_oe_n && !st.bus_busy)
      else $error("lines not released while idle");

   sda_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
      $changed(st.sda_oe_n) && st.scl_oe_n
      |-> $past(st.fsm) inside {csp_idle, csp_rs_high, csp_p_high})
      else $error("data moved while clock high");

   start_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
      cmd_valid && cmd_ready && scl_lvl && sda_lvl
      |=> !st.sda_oe_n && st.scl_oe_n && st.fsm == csp_start)
      else $error("start not issued on accept");

   stretch_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
      st.fsm == csp_rise && !scl_lvl |=> st.fsm == csp_rise && st.scl_oe_n)
      else $error("clock stretch not honoured");

   high_time_a: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(st.scl_oe_n) && $past(st.fsm) == csp_high |-> $past(st.cnt) == half)
      else $error("clock high phase wrong length");

   ack_release_a: assert property (@(posedge clk_sys) disable iff (reset)
      st.fsm == csp_high && st.bitn == `CSP_ACK_BIT && tx |-> st.sda_oe_n)
      else $error("data held on acknowledge pulse");

   last_nack_a: assert property (@(posedge clk_sys) disable iff (reset)
      st.fsm == csp_high && st.bitn == `CSP_ACK_BIT && !tx
      |-> st.sda_oe_n == !ack_ours)
      else $error("read acknowledge wrong");

   nack_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
      st.fsm == csp_high && st.cnt == half && st.bitn == `CSP_ACK_BIT && tx && sda_lvl
      |=> st.fsm == csp_p_low && st.rsp.nack)
      else $error("no stop after refusal");

   addr_byte_a: assert property (@(posedge clk_sys) disable iff (reset)
      $past(st.fsm) == csp_start && st.fsm == csp_low
      |-> st.shreg == {`CSP_SLAVE_ADDR, st.seg == csp_seg_addr_r})
      else $error("address byte wrong");

   word_order_a: assert property (@(posedge clk_sys) disable iff (reset)
      $changed(st.seg) && st.seg == csp_seg_whi |-> $past(st.seg) == csp_seg_wlo)
      else $error("high byte not after low byte");

endmodule : csp_master

//--- csp_pin_sync.sv
`timescale 1ns/100ps
`include "csp_defines.svh"

// ==========================================================
// three stage pin synchroniser, level moves when stages 2 and 3 agree
module csp_pin_sync
   import csp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic pin,
   output logic level
);

   csp_sync_t st;
   csp_sync_t next_st;

   // shift chain, first stage feeds only the second
   always_comb begin
      next_st = st;
      next_st.ff = {st.ff[1:0], pin};
      if (st.ff[1] == st.ff[2]) begin
         next_st.level = st.ff[2];
      end
   end

   // state register, bus idles high
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st.ff <= `CSP_SYNC_IDLE;
         st.level <= `CSP_LEVEL_HIGH;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;

endmodule : csp_pin_sync

//--- csp_pkg.sv
// ==========================================================
// shared types of the charger port master
package csp_pkg;
`include "csp_defines.svh"

   // ==========================================================
   // sequencer states
   typedef enum logic [3:0] {
      csp_idle, csp_start, csp_low, csp_rise, csp_high,
      csp_rs_low, csp_rs_rise, csp_rs_high,
      csp_p_low, csp_p_rise, csp_p_high, csp_p_done
   } csp_fsm_t;

   // byte currently on the bus
   typedef enum logic [2:0] {
      csp_seg_addr_w, csp_seg_reg, csp_seg_wlo, csp_seg_whi,
      csp_seg_addr_r, csp_seg_rlo, csp_seg_rhi
   } csp_seg_t;

   // register word, low byte goes first
   typedef struct packed {
      logic [`CSP_MSB:0] hi;
      logic [`CSP_MSB:0] lo;
   } csp_word_t;

   // one request from the user side
   typedef struct packed {
      logic rd;
      logic one_byte;
      logic [`CSP_MSB:0] reg_addr;
      csp_word_t wdata;
   } csp_cmd_t;

   // answer to a request
   typedef struct packed {
      logic nack;
      csp_word_t rdata;
   } csp_rsp_t;

   // whole state of the master
   typedef struct packed {
      csp_fsm_t fsm;
      csp_seg_t seg;
      logic [`CSP_CNT_W-1:0] cnt;
      logic [3:0] bitn;
      logic [`CSP_MSB:0] shreg;
      csp_cmd_t cmd;
      logic fast;
      logic scl_oe_n;
      logic sda_oe_n;
      logic pin_low;
      logic cmd_ready;
      logic bus_busy;
      logic rsp_valid;
      csp_rsp_t rsp;
   } csp_st_t;

   // pin synchroniser state
   typedef struct packed {
      logic [2:0] ff;
      logic level;
   } csp_sync_t;

endpackage : csp_pkg

//--- csp_slave_model.sv
`timescale 1ns/100ps

// ==========================================================
// behavioural charger device standing on the two-wire bus
module csp_slave_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3C // arbitrary value
) (
   input wire logic scl_line,
   input wire logic sda_line,
   input wire logic nack_addr,
   input wire logic [7:0] stretch_ns,
   output logic scl_oe_n,
   output logic sda_oe_n,
   output logic [7:0] addr_byte
);
   logic [7:0] regs [0:255];
   logic [7:0] ptr;
   logic [7:0] stage_lo;
   logic [7:0] stage_at;
   logic staged;
   logic restart;

   // only the mapped places answer, all others are refused
   function automatic logic defined(input logic [7:0] a);
      return (a <= 8'h0F) || (a >= 8'h20 && a <= 8'h3B);
   endfunction : defined

   // identity places always return their fixed codes
   function automatic logic [7:0] rd_reg(input logic [7:0] a);
      if (a == 8'h2E) return MAKER_CODE;
      if (a == 8'h2F) return PART_CODE;
      return regs[a];
   endfunction : rd_reg

   // low byte waits, the high byte right after it commits both together
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] b);
      if (a >= 8'h20 && a <= 8'h2F) return; // status and identity are read only
      if (!a[0]) begin
         stage_lo = b;
         stage_at = a;
         staged = 1'b1;
      end else if (staged && stage_at == a - 8'h01) begin // high first is dropped
         regs[stage_at] = stage_lo;
         regs[a] = b;
         staged = 1'b0;
      end
   endtask : wr_reg

   // eight bits sampled on clock rises, msb first
   task automatic rx(output logic [7:0] b);
      repeat (8) begin
         @(posedge scl_line);
         b = {b[6:0], sda_line};
      end
   endtask : rx

   // pull data low over the ninth pulse, stretching the clock meanwhile
   task automatic ack_bit();
      @(negedge scl_line);
      sda_oe_n = 1'b0;
      scl_oe_n = 1'b0;
      #(1300 + stretch_ns * 4); // outlasts the fast low phase, so the master really waits
      scl_oe_n = 1'b1;
      @(negedge scl_line);
      sda_oe_n = 1'b1;
   endtask : ack_bit

   // data changes only while the clock is low, released for the ack pulse
   task automatic tx(input logic [7:0] b, output logic acked);
      for (int i = 7; i >= 0; i--) begin
         sda_oe_n = b[i]; // open drain, a one is a release
         @(negedge scl_line);
      end
      sda_oe_n = 1'b1;
      @(posedge scl_line);
      acked = ~sda_line;
      @(negedge scl_line);
   endtask : tx

   // one addressed transfer after a start or repeated start
   task automatic transfer();
      logic [7:0] b;
      logic ok;
      rx(b);
      addr_byte = b;
      if (b[7:1] != 7'h09 || nack_addr) return;
      ack_bit();
      if (b[0]) begin
         ok = 1'b1;
         while (ok) begin
            tx(rd_reg(ptr), ok); // word reads walk up the map
            ptr = ptr + 8'h01;
         end
      end else begin
         rx(b);
         if (!defined(b)) return;
         ptr = b;
         ack_bit();
         forever begin
            rx(b);
            wr_reg(ptr, b);
            ptr = ptr + 8'h01;
            ack_bit();
         end
      end
   endtask : transfer

   // bus busy from a start until a stop, the slave never makes either
   initial begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
      staged = 1'b0;
      ptr = 8'h00;
      addr_byte = 8'h00;
      for (int i = 0; i < 256; i++) regs[i] = i[7:0] ^ 8'hA5;
      @(negedge sda_line iff scl_line === 1'b1);
      forever begin
         restart = 1'b0;
         fork : xfer
            begin
               transfer();
               wait (1'b0);
            end
            @(posedge sda_line iff scl_line === 1'b1); // stop
            begin
               @(negedge sda_line iff scl_line === 1'b1);
               restart = 1'b1;
            end
         join_any
         disable xfer;
         scl_oe_n = 1'b1;
         sda_oe_n = 1'b1;
         if (!restart) @(negedge sda_line iff scl_line === 1'b1);
      end
   end
endmodule : csp_slave_model

//--- tb.sv
`timescale 1ns/100ps

// ==========================================================
// self-checking bench for the charger port master
module tb;
   import csp_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic fast_mode = 1'b0;
   logic cmd_valid = 1'b0;
   csp_cmd_t cmd = '0;
   logic cmd_ready;
   logic rsp_valid;
   csp_rsp_t rsp;
   logic bus_busy;
   logic scl_drive;
   logic sda_drive;
   logic m_scl_oe_n;
   logic m_sda_oe_n;
   logic s_scl_oe_n;
   logic s_sda_oe_n;
   logic nack_addr = 1'b0;
   logic [7:0] stretch_ns = 8'h00;
   logic [7:0] addr_byte;
   logic [31:0] rnd = 32'h0000_0EB1;
   int error_cnt = 0;
   int n_tests = 0;
   // wired-and of both parties with pull-ups
   wire logic scl_line = m_scl_oe_n & s_scl_oe_n;
   wire logic sda_line = m_sda_oe_n & s_sda_oe_n;

   // 250 MHz system clock
   always #2 clk_sys = ~clk_sys;

   csp_master csp_master_inst (
      .clk_sys(clk_sys),
      .reset(reset),
      .fast_mode(fast_mode),
      .cmd_valid(cmd_valid),
      .cmd(cmd),
      .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid),
      .rsp(rsp),
      .bus_busy(bus_busy),
      .scl_sense(scl_line),
      .scl_drive(scl_drive),
      .scl_oe_n(m_scl_oe_n),
      .sda_sense(sda_line),
      .sda_drive(sda_drive),
      .sda_oe_n(m_sda_oe_n)
   );

   csp_slave_model csp_slave_model_inst (
      .scl_line(scl_line),
      .sda_line(sda_line),
      .nack_addr(nack_addr),
      .stretch_ns(stretch_ns),
      .scl_oe_n(s_scl_oe_n),
      .sda_oe_n(s_sda_oe_n),
      .addr_byte(addr_byte)
   );

   // xorshift source of repeatable values
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : next_rand

   // a writable word place of the map
   function automatic logic [7:0] pick_rw(input logic [3:0] x);
      return x[0] ? {4'h0, x[3:1], 1'b0} : {4'h3, 1'b0, x[2:1], 1'b0};
   endfunction : pick_rw

   // last address byte expected on the wire
   function automatic logic [7:0] addr_of(input logic rd);
      return {7'h09, rd};
   endfunction : addr_of

   // compare of single bits
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   // compare of bytes and words
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   // verdict and end of run
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // one word transfer: hold the request until taken, then wait for the answer
   task automatic run_cmd(input logic rd, input logic [7:0] ra, input csp_word_t wd,
                          output csp_rsp_t r);
      int n;
      @(posedge clk_sys);
      #1;
      cmd = '{rd: rd, one_byte: 1'b0, reg_addr: ra, wdata: wd};
      cmd_valid = 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (cmd_ready !== 1'b0 && n < 100);
      cmd_valid = 1'b0;
      chk_bit("cmd_ready after accept", 1'b0, cmd_ready);
      repeat (200) @(posedge clk_sys);
      #1;
      chk_bit("bus_busy during transfer", 1'b1, bus_busy);
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 60000);
      chk_bit("rsp_valid", 1'b1, rsp_valid);
      chk_bit("cmd_ready with response", 1'b1, cmd_ready);
      r = rsp;
      chk_val("address byte", {8'h00, addr_of(rd)}, {8'h00, addr_byte});
      repeat (2) @(posedge clk_sys);
      #1;
      chk_bit("bus_busy after stop", 1'b0, bus_busy);
      chk_bit("scl idle", 1'b1, scl_line);
      chk_bit("sda idle", 1'b1, sda_line);
      chk_bit("open drain value", 1'b0, scl_drive | sda_drive);
   endtask : run_cmd

   // main sequence
   initial begin
      csp_rsp_t r;
      csp_word_t wd;
      logic [7:0] ra;
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      // standard rate, address refused by the device
      nack_addr = 1'b1;
      run_cmd(1'b0, 8'h0C, 16'h1234, r);
      chk_bit("nack on address", 1'b1, r.nack);
      // fast rate word write then read back, device stretching the clock
      fast_mode = 1'b1;
      nack_addr = 1'b0;
      rnd = next_rand(rnd);
      stretch_ns = rnd[7:0];
      ra = pick_rw(rnd[11:8]);
      wd = rnd[31:16];
      run_cmd(1'b0, ra, wd, r);
      chk_bit("write nack", 1'b0, r.nack);
      rnd = next_rand(rnd);
      stretch_ns = rnd[7:0];
      run_cmd(1'b1, ra, 16'h0000, r);
      chk_bit("read nack", 1'b0, r.nack);
      chk_val("read word", wd, r.rdata);
      // write to an unmapped place is refused
      rnd = next_rand(rnd);
      run_cmd(1'b0, {4'h1, rnd[3:0]}, rnd[31:16], r);
      chk_bit("unmapped nack", 1'b1, r.nack);
      tally_and_finish();
   end

   // watchdog against a hung transfer
   initial begin
      repeat (100000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb
